/* hw/dsc_pkg.sv */
// shared constants and types of the serial debug command decoder
package dsc_pkg;

  // serial packet: status/control bit plus 16 data bits
  localparam int            XFER_BITS  = 17;
  localparam logic [4:0]    XFER_LAST  = 5'(XFER_BITS - 1);
  localparam logic [2:0]    ADDR_WORDS = 3'h2;

  // operation field codes (bits 15..10 of the operation word)
  localparam logic [5:0]    OP_NULL     = 6'h00;
  localparam logic [5:0]    OP_GO       = 6'h03;
  localparam logic [5:0]    OP_MEM      = 6'h06;
  localparam logic [5:0]    OP_BLOCK    = 6'h07;
  localparam logic [5:0]    OP_CPU_REG  = 6'h08;
  localparam logic [5:0]    OP_CTRL_REG = 6'h0A;
  localparam logic [5:0]    OP_DBG_REG  = 6'h0B;

  // operand_size_field encodings
  localparam logic [1:0]    SZ_BYTE = 2'h0;
  localparam logic [1:0]    SZ_WORD = 2'h1;
  localparam logic [1:0]    SZ_LONG = 2'h2;
  localparam logic [1:0]    SZ_RSVD = 2'h3;

  // 17-bit responses sent to the host
  localparam logic [16:0]   RSP_NOT_READY = 17'h10000;
  localparam logic [16:0]   RSP_BUS_ERR   = 17'h10001;
  localparam logic [16:0]   RSP_ILLEGAL   = 17'h1FFFF;
  localparam logic [16:0]   RSP_DONE      = 17'h0FFFF;

  // reset values
  localparam logic [31:0]   ADDR_RESET = 32'h0000_0000;
  localparam logic [16:0]   RES_RESET  = 17'h0FFFF;

  // operation word layout, bit 15 first
  typedef struct packed {
    logic [5:0] op;
    logic       zero9;
    logic       rw;
    logic [1:0] size;
    logic       zero5;
    logic       zero4;
    logic       ad;
    logic [2:0] regn;
  } dsc_cmd_t;

  typedef enum logic [1:0] {SPACE_CPU, SPACE_CTRL, SPACE_DBG} dsc_space_t;

  // register access selector toward the core
  typedef struct packed {
    dsc_space_t  space;
    logic        ad;
    logic [2:0]  regn;
    logic [11:0] creg;
  } dsc_reg_sel_t;

endpackage

/* hw/dsc_decoder.sv */
// serial debug port command decoder and dispatcher
//
// Our own choices: the placing of the registers and register access by a request held until acknowledge.
`timescale 1ns/10ps
module dsc_decoder (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  dsclk_in,
  input  wire logic                  dsi_in,
  output logic                       dso_out,
  input  wire logic                  cpu_halted_in,
  output logic                       reg_req_out,
  output logic                       reg_we_out,
  output dsc_pkg::dsc_reg_sel_t      reg_sel_out,
  output logic [31:0]                reg_wdata_out,
  input  wire logic [31:0]           reg_rdata_in,
  input  wire logic                  reg_ack_in,
  output logic                       mem_req_out,
  output logic                       mem_we_out,
  output logic [31:0]                mem_addr_out,
  output logic [1:0]                 mem_size_out,
  output logic [31:0]                mem_wdata_out,
  input  wire logic [31:0]           mem_rdata_in,
  input  wire logic                  mem_ack_in,
  input  wire logic                  mem_err_in,
  output logic                       resume_out
);
  import dsc_pkg::*;

  typedef enum logic [2:0] {ST_OPWORD, ST_EXT, ST_EXEC, ST_REG, ST_MEM} dsc_state_t;

  function automatic logic is_illegal(input dsc_cmd_t c);
    logic bad;
    bad = c.zero9 | c.zero5 | c.zero4;
    case (c.op)
      OP_NULL, OP_GO, OP_CPU_REG, OP_CTRL_REG, OP_DBG_REG: ;
      OP_MEM, OP_BLOCK: bad = bad | (c.size == SZ_RSVD);
      default: bad = 1'b1;
    endcase
    return bad;
  endfunction

  // extension words that follow an operation word
  function automatic logic [2:0] ext_words(input dsc_cmd_t c);
    logic [2:0] dw;
    dw = (c.size == SZ_LONG) ? 3'h2 : 3'h1;
    case (c.op)
      OP_CPU_REG:  return c.rw ? 3'h0 : 3'h2;
      OP_MEM:      return c.rw ? ADDR_WORDS : 3'(ADDR_WORDS + dw);
      OP_BLOCK:    return c.rw ? 3'h0 : dw;
      OP_CTRL_REG: return c.rw ? ADDR_WORDS : 3'(ADDR_WORDS + 3'h2);
      OP_DBG_REG:  return c.rw ? 3'h0 : 3'h2;
      default:     return 3'h0;
    endcase
  endfunction

  function automatic logic [2:0] addr_words(input dsc_cmd_t c);
    return (c.op == OP_MEM || c.op == OP_CTRL_REG) ? ADDR_WORDS : 3'h0;
  endfunction

  // natural alignment of memory operands
  function automatic logic [31:0] align(input logic [31:0] a, input logic [1:0] s);
    case (s)
      SZ_WORD: return {a[31:1], 1'b0};
      SZ_LONG: return {a[31:2], 2'b00};
      default: return a;
    endcase
  endfunction

  function automatic logic [31:0] step(input logic [1:0] s);
    case (s)
      SZ_WORD: return 32'h0000_0002;
      SZ_LONG: return 32'h0000_0004;
      default: return 32'h0000_0001;
    endcase
  endfunction

  // link pins cross from the host's domain: two flops, then an edge detector
  logic        clk_s1_q, clk_s2_q, clk_s3_q, dsi_s1_q, dsi_s2_q;
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_s1_q <= 1'b0;
      clk_s2_q <= 1'b0;
      clk_s3_q <= 1'b0;
      dsi_s1_q <= 1'b0;
      dsi_s2_q <= 1'b0;
    end else begin
      clk_s1_q <= dsclk_in;
      clk_s2_q <= clk_s1_q;
      clk_s3_q <= clk_s2_q;
      dsi_s1_q <= dsi_in;
      dsi_s2_q <= dsi_s1_q;
    end
  end
  logic        link_edge;
  assign link_edge = clk_s2_q & ~clk_s3_q;

  dsc_state_t   state_q, state_d;
  dsc_cmd_t     cmd_q, cmd_d;
  logic [2:0]   need_q, need_d, aleft_q, aleft_d;
  logic [31:0]  addr_q, addr_d, data_q, data_d;
  logic [16:0]  res0_q, res0_d, res1_q, res1_d;
  logic [1:0]   rcnt_q, rcnt_d;
  logic [15:0]  rx_q, rx_d, tx_q, tx_d;
  logic [4:0]   bit_q, bit_d;
  logic         dso_d, rreq_d, rwe_d, mreq_d, mwe_d, resume_d;
  dsc_reg_sel_t rsel_d;
  logic [31:0]  rwd_d, maddr_d, mwd_d;
  logic [1:0]   msize_d;
  logic         word_done;
  logic [15:0]  word_in;
  logic [16:0]  resp;
  logic         need_halt;

  always_comb begin
    state_d  = state_q;
    cmd_d    = cmd_q;
    need_d   = need_q;
    aleft_d  = aleft_q;
    addr_d   = addr_q;
    data_d   = data_q;
    res0_d   = res0_q;
    res1_d   = res1_q;
    rcnt_d   = rcnt_q;
    rx_d     = rx_q;
    tx_d     = tx_q;
    bit_d    = bit_q;
    dso_d    = dso_out;
    rreq_d   = reg_req_out;
    rwe_d    = reg_we_out;
    rsel_d   = reg_sel_out;
    rwd_d    = reg_wdata_out;
    mreq_d   = mem_req_out;
    mwe_d    = mem_we_out;
    maddr_d  = mem_addr_out;
    msize_d  = mem_size_out;
    mwd_d    = mem_wdata_out;
    resume_d = 1'b0;
    word_done = 1'b0;
    word_in  = {rx_q[14:0], dsi_s2_q};
    // pending results first, then busy, then plain completion
    if (rcnt_q != 2'h0) resp = res0_q;
    else if (state_q != ST_OPWORD) resp = RSP_NOT_READY;
    else resp = RSP_DONE;
    // stolen-cycle memory work and parallel commands never wait for a halt
    need_halt = !(cmd_q.op == OP_DBG_REG && cmd_q.rw) && cmd_q.op != OP_NULL &&
                cmd_q.op != OP_MEM && cmd_q.op != OP_BLOCK;

    // full duplex shifter; the answer word is chosen at a transfer's first edge
    if (link_edge) begin
      rx_d = word_in;
      if (bit_q == 5'h00) begin
        dso_d = resp[16];
        tx_d  = resp[15:0];
        if (rcnt_q != 2'h0) begin
          res0_d = res1_q;
          rcnt_d = rcnt_q - 2'h1;
        end
      end else begin
        dso_d = tx_q[15];
        tx_d  = {tx_q[14:0], 1'b0};
      end
      if (bit_q == XFER_LAST) begin
        bit_d     = 5'h00;
        word_done = 1'b1;
      end else begin
        bit_d = bit_q + 5'h01;
      end
    end

    case (state_q)
      ST_OPWORD: if (word_done) begin
        if (is_illegal(word_in)) begin
          res0_d = RSP_ILLEGAL;
          rcnt_d = 2'h1;
        end else begin
          cmd_d   = word_in;
          need_d  = ext_words(word_in);
          aleft_d = addr_words(word_in);
          state_d = (ext_words(word_in) == 3'h0) ? ST_EXEC : ST_EXT;
        end
      end
      ST_EXT: if (word_done) begin
        if (aleft_q != 3'h0) begin
          addr_d  = {addr_q[15:0], word_in};
          aleft_d = aleft_q - 3'h1;
        end else begin
          data_d = {data_q[15:0], word_in};
        end
        need_d = need_q - 3'h1;
        if (need_q == 3'h1) state_d = ST_EXEC;
      end
      ST_EXEC: begin
        state_d = ST_OPWORD;
        // a null sent beside a two-word answer must not clobber the low word
        if (cmd_q.op != OP_NULL || rcnt_q == 2'h0) begin
          rcnt_d = 2'h1;
          res0_d = RSP_DONE;
        end
        if (need_halt && !cpu_halted_in) begin
          res0_d = RSP_BUS_ERR;
        end else begin
          case (cmd_q.op)
            OP_CPU_REG, OP_CTRL_REG, OP_DBG_REG: begin
              rcnt_d       = 2'h0;
              rreq_d       = 1'b1;
              rwe_d        = !cmd_q.rw;
              rsel_d.space = (cmd_q.op == OP_CPU_REG) ? SPACE_CPU :
                             (cmd_q.op == OP_CTRL_REG) ? SPACE_CTRL : SPACE_DBG;
              rsel_d.ad    = cmd_q.ad;
              rsel_d.regn  = cmd_q.regn;
              rsel_d.creg  = addr_q[11:0];
              rwd_d        = data_q;
              state_d      = ST_REG;
            end
            OP_MEM, OP_BLOCK: begin
              rcnt_d  = 2'h0;
              // block commands advance from the previous access address
              if (cmd_q.op == OP_BLOCK) addr_d = align(addr_q, cmd_q.size) + step(cmd_q.size);
              else addr_d = align(addr_q, cmd_q.size);
              maddr_d = addr_d;
              mreq_d  = 1'b1;
              mwe_d   = !cmd_q.rw;
              msize_d = cmd_q.size;
              mwd_d   = data_q;
              state_d = ST_MEM;
            end
            OP_GO: resume_d = 1'b1;
            default: ;
          endcase
        end
      end
      ST_REG: if (reg_ack_in) begin
        rreq_d  = 1'b0;
        state_d = ST_OPWORD;
        if (cmd_q.rw) begin
          res0_d = {1'b0, reg_rdata_in[31:16]};
          res1_d = {1'b0, reg_rdata_in[15:0]};
          rcnt_d = 2'h2;
        end else begin
          res0_d = RSP_DONE;
          rcnt_d = 2'h1;
        end
      end
      ST_MEM: if (mem_ack_in) begin
        mreq_d  = 1'b0;
        state_d = ST_OPWORD;
        rcnt_d  = 2'h1;
        if (mem_err_in) res0_d = RSP_BUS_ERR;
        else if (!cmd_q.rw) res0_d = RSP_DONE;
        else if (cmd_q.size == SZ_LONG) begin
          res0_d = {1'b0, mem_rdata_in[31:16]};
          res1_d = {1'b0, mem_rdata_in[15:0]};
          rcnt_d = 2'h2;
        end else res0_d = {1'b0, mem_rdata_in[15:0]};
      end
      default: state_d = ST_OPWORD;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q       <= ST_OPWORD;
      cmd_q         <= '0;
      need_q        <= 3'h0;
      aleft_q       <= 3'h0;
      addr_q        <= ADDR_RESET;
      data_q        <= 32'h0000_0000;
      res0_q        <= RES_RESET;
      res1_q        <= RES_RESET;
      rcnt_q        <= 2'h0;
      rx_q          <= 16'h0000;
      tx_q          <= 16'h0000;
      bit_q         <= 5'h00;
      dso_out       <= 1'b0;
      reg_req_out   <= 1'b0;
      reg_we_out    <= 1'b0;
      reg_sel_out   <= '0;
      reg_wdata_out <= 32'h0000_0000;
      mem_req_out   <= 1'b0;
      mem_we_out    <= 1'b0;
      mem_addr_out  <= 32'h0000_0000;
      mem_size_out  <= SZ_BYTE;
      mem_wdata_out <= 32'h0000_0000;
      resume_out    <= 1'b0;
    end else begin
      state_q       <= state_d;
      cmd_q         <= cmd_d;
      need_q        <= need_d;
      aleft_q       <= aleft_d;
      addr_q        <= addr_d;
      data_q        <= data_d;
      res0_q        <= res0_d;
      res1_q        <= res1_d;
      rcnt_q        <= rcnt_d;
      rx_q          <= rx_d;
      tx_q          <= tx_d;
      bit_q         <= bit_d;
      dso_out       <= dso_d;
      reg_req_out   <= rreq_d;
      reg_we_out    <= rwe_d;
      reg_sel_out   <= rsel_d;
      reg_wdata_out <= rwd_d;
      mem_req_out   <= mreq_d;
      mem_we_out    <= mwe_d;
      mem_addr_out  <= maddr_d;
      mem_size_out  <= msize_d;
      mem_wdata_out <= mwd_d;
      resume_out    <= resume_d;
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  a_halt_reg_blocked: assert property (
    (state_q == ST_EXEC && cmd_q.op == OP_CPU_REG && !cpu_halted_in)
      |=> !reg_req_out && rcnt_q == 2'h1 && res0_q == RSP_BUS_ERR)
    else $error("register command ran while cpu was running");

  a_go_needs_halt: assert property (
    resume_out |-> $past(cpu_halted_in) && $past(state_q) == ST_EXEC)
    else $error("resume issued without a halted cpu");

  a_mem_aligned: assert property (
    mem_req_out && mem_size_out == SZ_LONG |-> mem_addr_out[1:0] == 2'b00)
    else $error("long memory access not aligned");

  a_dbg_read_running: assert property (
    (state_q == ST_EXEC && cmd_q.op == OP_DBG_REG && cmd_q.rw)
      |=> reg_req_out && reg_sel_out.space == SPACE_DBG)
    else $error("debug register read did not start");

  a_illegal_reply: assert property (
    (word_done && state_q == ST_OPWORD && is_illegal(word_in))
      |=> state_q == ST_OPWORD && res0_q == RSP_ILLEGAL)
    else $error("illegal command not answered as illegal");

  a_reg_dir: assert property (
    $rose(reg_req_out) |-> reg_we_out == !cmd_q.rw)
    else $error("register direction does not follow bit 8");

  a_mem_req_hold: assert property (
    mem_req_out && !mem_ack_in |=> mem_req_out && $stable(mem_addr_out))
    else $error("memory request dropped before acknowledge");

  a_block_step: assert property (
    (state_q == ST_EXEC && cmd_q.op == OP_BLOCK)
      |=> mem_addr_out == align($past(addr_q), cmd_q.size) + step(cmd_q.size))
    else $error("block access did not advance by operand size");

  a_null_quiet: assert property (
    (state_q == ST_EXEC && cmd_q.op == OP_NULL)
      |=> !mem_req_out && !reg_req_out && !resume_out &&
          res0_q == (($past(rcnt_q) == 2'h0) ? RSP_DONE : $past(res0_q)))
    else $error("null command had a side effect");

  a_ext_count: assert property (
    (word_done && state_q == ST_OPWORD && !is_illegal(word_in) && ext_words(word_in) != 3'h0)
      |=> state_q == ST_EXT && need_q == ext_words(cmd_q))
    else $error("wrong extension word count");

  c_mem_read: cover property ($rose(mem_req_out) && !mem_we_out);
  c_block_fill: cover property (state_q == ST_EXEC && cmd_q.op == OP_BLOCK && !cmd_q.rw);
  c_reg_reject: cover property (state_q == ST_EXEC && cmd_q.op == OP_CTRL_REG && !cpu_halted_in);
  c_resume: cover property (resume_out);
endmodule

/* sim/dsc_host_model.sv */
// serial debug host model: clocks out 17-bit words and collects the answers
`timescale 1ns/10ps
module dsc_host_model (
  input  wire logic sys_clk_in,
  input  wire logic dso_in,
  output logic      dsclk_out,
  output logic      dsi_out
);
  initial begin
    dsclk_out = 1'h0;
    dsi_out   = 1'h0;
  end

  // one transfer, 8 sys clocks a bit; the link clock stands low between words
  task automatic xfer(input logic [15:0] word, output logic [16:0] rx);
    logic [16:0] tx;
    tx = {1'h0, word};
    for (int i = 16; i >= 0; i--) begin
      @(posedge sys_clk_in);
      dsclk_out <= 1'h1;
      dsi_out   <= tx[i];
      repeat (4) @(posedge sys_clk_in);
      dsclk_out <= 1'h0;
      dsi_out   <= ~tx[i];
      // answer bit is settled well before the next rise
      repeat (3) @(posedge sys_clk_in);
      rx[i] = dso_in;
    end
    // idle gap; data line toggles so a stale value is never read as valid
    repeat (8) begin
      @(posedge sys_clk_in);
      dsi_out <= ~dsi_out;
    end
  endtask
endmodule

/* sim/dsc_decoder_test.sv */
// self-checking bench of the serial debug command decoder
`timescale 1ns/10ps
module dsc_decoder_test;
  import dsc_pkg::*;
  logic          sys_clk_in = 1'h0;
  logic          rst_n_in;
  logic          dsclk_in;
  logic          dsi_in;
  logic          dso_out;
  logic          cpu_halted_in;
  logic          reg_req_out;
  logic          reg_we_out;
  dsc_reg_sel_t  reg_sel_out;
  logic [31:0]   reg_wdata_out;
  logic [31:0]   reg_rdata_in;
  logic          reg_ack_in;
  logic          mem_req_out;
  logic          mem_we_out;
  logic [31:0]   mem_addr_out;
  logic [1:0]    mem_size_out;
  logic [31:0]   mem_wdata_out;
  logic [31:0]   mem_rdata_in;
  logic          mem_ack_in;
  logic          mem_err_in;
  logic          resume_out;
  logic          err_next;
  logic [3:0]    rc = 4'h0;
  logic [3:0]    mc = 4'h0;
  dsc_reg_sel_t  lsel;
  logic          lwe;
  logic [31:0]   lwd;
  logic          mwe;
  logic [31:0]   madr;
  logic [1:0]    msz;
  logic [31:0]   mwd;
  int            n_reg = 0;
  int            n_res = 0;
  int            fails = 0;
  int            n_checks = 0;

  always #20 sys_clk_in = ~sys_clk_in;

  dsc_decoder dsc_decoder_i (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .dsclk_in(dsclk_in),
    .dsi_in(dsi_in), .dso_out(dso_out), .cpu_halted_in(cpu_halted_in), .reg_req_out(reg_req_out),
    .reg_we_out(reg_we_out), .reg_sel_out(reg_sel_out), .reg_wdata_out(reg_wdata_out),
    .reg_rdata_in(reg_rdata_in), .reg_ack_in(reg_ack_in), .mem_req_out(mem_req_out),
    .mem_we_out(mem_we_out), .mem_addr_out(mem_addr_out), .mem_size_out(mem_size_out),
    .mem_wdata_out(mem_wdata_out), .mem_rdata_in(mem_rdata_in), .mem_ack_in(mem_ack_in),
    .mem_err_in(mem_err_in), .resume_out(resume_out));

  dsc_host_model dsc_host_model_i (.sys_clk_in(sys_clk_in), .dso_in(dso_out), .dsclk_out(dsclk_in),
    .dsi_out(dsi_in));

  function automatic logic [31:0] mdata(input logic [31:0] a);
    return {a[15:0] ^ 16'h5A5A, ~a[15:0]};
  endfunction

  function automatic logic [15:0] opw(input logic [5:0] op, input logic rw, input logic [1:0] sz,
                                      input logic ad, input logic [2:0] r);
    return {op, 1'h0, rw, sz, 2'h0, ad, r};
  endfunction

  // core side: acks each access three cycles after the request rises
  always @(posedge sys_clk_in) begin
    if (reg_ack_in) begin
      reg_ack_in <= 1'h0;
      rc         <= 4'h0;
    end else if (reg_req_out === 1'h1) begin
      rc <= rc + 4'h1;
      if (rc == 4'h2) begin
        reg_ack_in   <= 1'h1;
        reg_rdata_in <= 32'hCAFE_0000 | 32'(reg_sel_out.regn);
        lsel         <= reg_sel_out;
        lwe          <= reg_we_out;
        lwd          <= reg_wdata_out;
        n_reg++;
      end
    end
    if (mem_ack_in) begin
      mem_ack_in <= 1'h0;
      mem_err_in <= 1'h0;
      mc         <= 4'h0;
    end else if (mem_req_out === 1'h1) begin
      mc <= mc + 4'h1;
      if (mc == 4'h2) begin
        mem_ack_in   <= 1'h1;
        mem_err_in   <= err_next;
        mem_rdata_in <= mdata(mem_addr_out);
        mwe          <= mem_we_out;
        madr         <= mem_addr_out;
        msz          <= mem_size_out;
        mwd          <= mem_wdata_out;
      end
    end
    if (resume_out === 1'h1) n_res++;
  end

  task automatic chk_rsp(input logic [16:0] g, input logic [16:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t answer %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("BAD %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic x(input logic [15:0] w, output logic [16:0] r);
    dsc_host_model_i.xfer(w, r);
  endtask

  // opcode answered with done, extension words with not-ready
  task automatic cmd(input logic [15:0] w[$]);
    logic [16:0] r;
    foreach (w[i]) begin
      x(w[i], r);
      chk_rsp(r, (i == 0) ? RSP_DONE : RSP_NOT_READY);
    end
  endtask

  // null words until the answer is no longer not-ready
  task automatic poll(output logic [16:0] r);
    int k;
    k = 0;
    r = RSP_NOT_READY;
    while (r === RSP_NOT_READY && k < 30) begin
      x(16'h0000, r);
      k++;
    end
    if (r === RSP_NOT_READY) begin
      fails++;
      $display("BAD %0t no answer", $time);
    end
  endtask

  task automatic read2(input logic [31:0] e);
    logic [16:0] r;
    poll(r);
    chk_rsp(r, {1'h0, e[31:16]});
    x(16'h0000, r);
    chk_rsp(r, {1'h0, e[15:0]});
  endtask

  task automatic t_mem_read;
    logic [16:0] r;
    logic [31:0] e;
    e = mdata(32'h0002_1940);
    cmd('{opw(OP_MEM, 1'h1, SZ_WORD, 1'h0, 3'h0), 16'h0002, 16'h1941});
    poll(r);
    chk_rsp(r, {1'h0, e[15:0]});
    chk_val(madr, 32'h0002_1940);
    chk_val({mwe, 29'h0, msz}, {1'h0, 29'h0, SZ_WORD});
    cmd('{opw(OP_MEM, 1'h1, SZ_LONG, 1'h0, 3'h0), 16'h0002, 16'h1947});
    read2(mdata(32'h0002_1944));
    chk_val(madr, 32'h0002_1944);
    err_next = 1'h1;
    cmd('{opw(OP_MEM, 1'h1, SZ_BYTE, 1'h0, 3'h0), 16'h0002, 16'h1003});
    poll(r);
    chk_rsp(r, RSP_BUS_ERR);
    err_next = 1'h0;
    $display("test mem_read done");
  endtask

  task automatic t_dump;
    cmd('{opw(OP_MEM, 1'h1, SZ_LONG, 1'h0, 3'h0), 16'h0003, 16'h0000});
    read2(mdata(32'h0003_0000));
    for (int i = 1; i <= 2; i++) begin
      cmd('{opw(OP_BLOCK, 1'h1, SZ_LONG, 1'h0, 3'h0)});
      read2(mdata(32'h0003_0000 + 32'(4 * i)));
      chk_val(madr, 32'h0003_0000 + 32'(4 * i));
    end
    $display("test dump done");
  endtask

  task automatic t_fill;
    logic [16:0] r;
    cmd('{opw(OP_MEM, 1'h0, SZ_BYTE, 1'h0, 3'h0), 16'h0004, 16'h0101, 16'h00AB});
    poll(r);
    chk_rsp(r, RSP_DONE);
    chk_val({mwe, 29'h0, msz}, {1'h1, 29'h0, SZ_BYTE});
    chk_val({madr, mwd[7:0]}, {32'h0004_0101, 8'hAB});
    cmd('{opw(OP_BLOCK, 1'h0, SZ_BYTE, 1'h0, 3'h0), 16'h00CD});
    poll(r);
    chk_rsp(r, RSP_DONE);
    chk_val({madr, mwd[7:0]}, {32'h0004_0102, 8'hCD});
    cmd('{opw(OP_MEM, 1'h0, SZ_LONG, 1'h0, 3'h0), 16'h0004, 16'h0300, 16'h1122, 16'h3344});
    poll(r);
    chk_val(mwd, 32'h1122_3344);
    $display("test fill done");
  endtask

  task automatic t_illegal;
    logic [16:0] r;
    logic [15:0] bad[3];
    bad = '{16'h0200, opw(6'h3F, 1'h0, SZ_WORD, 1'h0, 3'h0), opw(OP_MEM, 1'h1, SZ_RSVD, 1'h0, 3'h0)};
    foreach (bad[i]) begin
      cmd('{bad[i]});
      poll(r);
      chk_rsp(r, RSP_ILLEGAL);
    end
    $display("test illegal done");
  endtask

  task automatic t_running;
    logic [16:0] r;
    int n0;
    n0 = n_reg;
    cmd('{opw(OP_CPU_REG, 1'h0, SZ_LONG, 1'h1, 3'h5), 16'h1111, 16'h2222});
    poll(r);
    chk_rsp(r, RSP_BUS_ERR);
    chk_val(32'(n_reg - n0), 32'h0);
    cmd('{opw(OP_DBG_REG, 1'h1, SZ_LONG, 1'h0, 3'h4)});
    read2(32'hCAFE_0004);
    chk_val({30'h0, lsel.space}, {30'h0, SPACE_DBG});
    cmd('{16'h0000});
    poll(r);
    chk_rsp(r, RSP_DONE);
    n0 = n_res;
    cmd('{opw(OP_GO, 1'h0, SZ_BYTE, 1'h0, 3'h0)});
    poll(r);
    chk_rsp(r, RSP_BUS_ERR);
    chk_val(32'(n_res - n0), 32'h0);
    $display("test running done");
  endtask

  task automatic t_regs;
    logic [16:0] r;
    cmd('{opw(OP_CPU_REG, 1'h0, SZ_LONG, 1'h1, 3'h5), 16'h1122, 16'h3344});
    poll(r);
    chk_val({lwe, lsel.ad, lsel.regn, lwd}, {1'h1, 1'h1, 3'h5, 32'h1122_3344});
    cmd('{opw(OP_CPU_REG, 1'h1, SZ_LONG, 1'h0, 3'h2)});
    read2(32'hCAFE_0002);
    chk_val({lwe, lsel.ad, lsel.regn}, {1'h0, 1'h0, 3'h2});
    cmd('{opw(OP_CTRL_REG, 1'h1, SZ_LONG, 1'h0, 3'h0), 16'h0000, 16'h0801});
    read2(32'hCAFE_0000);
    chk_val({lsel.space, lsel.creg}, {SPACE_CTRL, 12'h801});
    cmd('{opw(OP_CTRL_REG, 1'h0, SZ_LONG, 1'h0, 3'h0), 16'h0000, 16'h0802, 16'h5566, 16'h7788});
    poll(r);
    chk_val({lwe, lsel.creg, lwd[15:0]}, {1'h1, 12'h802, 16'h7788});
    cmd('{opw(OP_DBG_REG, 1'h0, SZ_LONG, 1'h0, 3'h6), 16'h9ABC, 16'hDEF0});
    poll(r);
    chk_val({lsel.space, lwe, lwd}, {SPACE_DBG, 1'h1, 32'h9ABC_DEF0});
    $display("test regs done");
  endtask

  task automatic t_resume;
    logic [16:0] r;
    int n0;
    n0 = n_res;
    cmd('{opw(OP_GO, 1'h0, SZ_BYTE, 1'h0, 3'h0)});
    poll(r);
    chk_rsp(r, RSP_DONE);
    chk_val(32'(n_res - n0), 32'h1);
    $display("test resume done");
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    rst_n_in      = 1'h0;
    cpu_halted_in = 1'h0;
    reg_ack_in    = 1'h0;
    reg_rdata_in  = 32'h0;
    mem_ack_in    = 1'h0;
    mem_err_in    = 1'h0;
    mem_rdata_in  = 32'h0;
    err_next      = 1'h0;
    repeat (3) @(posedge sys_clk_in);
    rst_n_in <= 1'h1;
    repeat (3) @(posedge sys_clk_in);
    // memory work runs with the core running: cycles are stolen
    t_mem_read;
    t_dump;
    t_fill;
    t_illegal;
    t_running;
    cpu_halted_in <= 1'h1;
    t_regs;
    t_resume;
    final_report;
  end

  // about 80 transfers of some 150 cycles each, with a wide margin
  initial begin
    #2_400_000;
    fails++;
    $display("BAD %0t watchdog expired", $time);
    final_report;
  end
endmodule
